// File: core/uart_baud_status_errors.sv
// Purpose: APB register slave with baud divisor, line status and error-clear trigger.
// Assumes: Receive and transmit framing are simple shifters (8-bit receive, 10-bit transmit) timed by the bit tick.
// Notes: The channel operating clock is ref_clk; the bit tick times one serial bit.
`timescale 1ns/1ps
module uart_baud_status_errors (
    // Clock and reset.
    input wire logic ref_clk,
    input wire logic reset_n,
    // APB slave.
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Serial line.
    input wire logic rxLine,
    output logic txLine
);
    // ==========================================================
    // Declarations
    logic [7:0] baudDivisor_q;
    logic [7:0] channelControl_q;
    logic [7:0] frameFormat_q;
    logic [7:0] txBuffer_q;
    logic [7:0] rxBuffer_q;
    logic rxFull_q;
    logic overrun_q, framing_q, parity_q;
    logic txBufValid_q, txShiftActive_q;
    logic [2:0] clearPending_q;
    logic rxSync1_q, rxSync2_q;
    logic counterPulse, bitTick;
    logic operate, rxPermit, txPermit, rxOn, txOn;
    logic apbAccess, apbWrite, apbRead;
    uart_status_pkg::parity_mode_t parityMode;

    assign operate = channelControl_q[uart_status_pkg::OPERATE_BIT];
    assign rxPermit = channelControl_q[uart_status_pkg::RX_PERMIT_BIT];
    assign txPermit = channelControl_q[uart_status_pkg::TX_PERMIT_BIT];
    assign rxOn = operate && rxPermit;
    assign txOn = operate && txPermit;
    assign parityMode = uart_status_pkg::parity_mode_t'(
        frameFormat_q[uart_status_pkg::PARITY_LSB +: 2]);
    assign apbAccess = psel && penable;
    assign apbWrite = apbAccess && pwrite;
    assign apbRead = apbAccess && !pwrite;

    // ==========================================================
    // Baud generator
    baud_divider divider (
        .ref_clk(ref_clk),
        .reset_n(reset_n),
        .run(operate),
        .divisor(baudDivisor_q),
        .counterPulse(counterPulse),
        .bitTick(bitTick)
    );

    // Two-stage synchroniser for the receive pin.
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            rxSync1_q <= 1'b1;
            rxSync2_q <= 1'b1;
        end else begin
            rxSync1_q <= rxLine;
            rxSync2_q <= rxSync1_q;
        end
    end

    // ==========================================================
    // APB register writes
    // Zero wait states: the access phase completes in one cycle.
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            pready <= 1'b0;
        end else begin
            pready <= psel && !penable;
        end
    end

    // Control and format registers written by software.
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            baudDivisor_q <= uart_status_pkg::BAUD_DIVISOR_RESET;
            channelControl_q <= 8'h00;
            frameFormat_q <= 8'h00;
        end else if (apbWrite && pready) begin
            case (paddr)
                uart_status_pkg::BAUD_DIVISOR_ADDR: baudDivisor_q <= pwdata[7:0]; // [RULE_01]
                uart_status_pkg::CHANNEL_CONTROL_ADDR: channelControl_q <= pwdata[7:0];
                uart_status_pkg::FRAME_FORMAT_ADDR: frameFormat_q <= pwdata[7:0];
                default: ;
            endcase
        end
    end

    // Error-clear triggers act on the clock edge after the write completes.
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            clearPending_q <= 3'h0;
        end else if (apbWrite && pready && paddr == uart_status_pkg::ERROR_CLEAR_TRIGGER_ADDR) begin
            clearPending_q <= pwdata[2:0]; // [RULE_10] [RULE_12]
        end else begin
            clearPending_q <= 3'h0;
        end
    end

    // ==========================================================
    // Receiver
    typedef enum logic [1:0] {RX_IDLE, RX_DATA, RX_PARITY, RX_STOP} rx_state_t;
    rx_state_t rxState_q;
    logic [3:0] rxCount_q;
    logic [7:0] rxShift_q;
    logic rxParityBit_q;
    logic rxDone, rxFrameErr, rxParityErr;
    logic readRx;

    assign readRx = apbRead && pready && paddr == uart_status_pkg::RX_BUFFER_ADDR;

    // Steps through data, optional parity and the first stop bit only.
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            rxState_q <= RX_IDLE;
            rxCount_q <= 4'h0;
            rxShift_q <= 8'h00;
            rxParityBit_q <= 1'b0;
        end else if (!rxOn) begin
            rxState_q <= RX_IDLE;
            rxCount_q <= 4'h0;
        end else if (bitTick) begin
            case (rxState_q)
                RX_IDLE: begin
                    if (!rxSync2_q) begin
                        rxState_q <= RX_DATA;
                        rxCount_q <= 4'h0;
                    end
                end
                RX_DATA: begin
                    rxShift_q <= {rxSync2_q, rxShift_q[7:1]};
                    rxCount_q <= rxCount_q + 4'h1;
                    if (rxCount_q == uart_status_pkg::DATA_BITS - 4'h1) begin
                        rxState_q <= (parityMode == uart_status_pkg::PARITY_NONE) ?
                            RX_STOP : RX_PARITY;
                    end
                end
                RX_PARITY: begin
                    rxParityBit_q <= rxSync2_q;
                    rxState_q <= RX_STOP;
                end
                RX_STOP: rxState_q <= RX_IDLE; // [RULE_07]
                default: rxState_q <= RX_IDLE;
            endcase
        end
    end

    assign rxDone = rxOn && bitTick && rxState_q == RX_STOP;
    assign rxFrameErr = !rxSync2_q; // [RULE_06] [RULE_07]
    // Odd mode wants odd total ones; even mode wants even; zero mode checks nothing.
    always_comb begin
        case (parityMode)
            uart_status_pkg::PARITY_ODD: rxParityErr = ~(^rxShift_q ^ rxParityBit_q); // [RULE_08]
            uart_status_pkg::PARITY_EVEN: rxParityErr = ^rxShift_q ^ rxParityBit_q;
            default: rxParityErr = 1'b0; // [RULE_19]
        endcase
    end

    // Receive buffer keeps its unread byte when an overrun happens.
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            rxBuffer_q <= 8'h00;
            rxFull_q <= 1'b0;
        end else if (!operate) begin
            rxBuffer_q <= 8'h00; // [RULE_20]
            rxFull_q <= 1'b0;
        end else if (rxDone && (!rxFull_q || readRx)) begin
            rxBuffer_q <= rxShift_q;
            rxFull_q <= 1'b1;
        end else if (rxDone) begin
            rxFull_q <= 1'b1; // [RULE_05]
        end else if (readRx) begin
            rxFull_q <= 1'b0;
        end
    end

    // Error flags: set wins over a trigger clear; disabling wipes them.
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            overrun_q <= 1'b0;
            framing_q <= 1'b0;
            parity_q <= 1'b0;
        end else if (!rxOn) begin
            overrun_q <= 1'b0; // [RULE_09] [RULE_20]
            framing_q <= 1'b0;
            parity_q <= 1'b0;
        end else begin
            overrun_q <= (rxDone && rxFull_q && !readRx) ||
                (overrun_q && !clearPending_q[0]); // [RULE_04] [RULE_10]
            framing_q <= (rxDone && rxFrameErr) ||
                (framing_q && !clearPending_q[1]); // [RULE_06] [RULE_10]
            parity_q <= (rxDone && rxParityErr) ||
                (parity_q && !clearPending_q[2]); // [RULE_08] [RULE_10]
        end
    end

    // ==========================================================
    // Transmitter
    logic [3:0] txCount_q;
    logic [9:0] txShift_q;
    logic txLoad, txEnd, txWrite;

    // Loads wait for a bit tick, so the start bit lasts one full bit time.
    assign txWrite = apbWrite && pready && paddr == uart_status_pkg::TX_BUFFER_ADDR;
    assign txEnd = txShiftActive_q && bitTick && txCount_q == 4'h0;
    assign txLoad = txOn && txBufValid_q && bitTick && (!txShiftActive_q || txEnd);

    // Buffer-valid flag follows writes and loads into the shifter.
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            txBuffer_q <= 8'h00;
            txBufValid_q <= 1'b0;
        end else if (!txOn) begin
            txBufValid_q <= 1'b0; // [RULE_13] [RULE_20]
        end else if (txWrite) begin
            txBuffer_q <= pwdata[7:0];
            txBufValid_q <= 1'b1; // [RULE_13]
        end else if (txLoad) begin
            txBufValid_q <= 1'b0; // [RULE_13]
        end
    end

    // Shift-active flag and shifter: start, eight data, one stop.
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            txShiftActive_q <= 1'b0;
            txShift_q <= 10'h3FF;
            txCount_q <= 4'h0;
        end else if (!txOn) begin
            txShiftActive_q <= 1'b0; // [RULE_14]
            txShift_q <= 10'h3FF;
            txCount_q <= 4'h0;
        end else if (txLoad) begin
            txShiftActive_q <= 1'b1; // [RULE_14]
            txShift_q <= {1'b1, txBuffer_q, 1'b0};
            txCount_q <= 4'h9;
        end else if (txEnd) begin
            txShiftActive_q <= 1'b0; // [RULE_14]
        end else if (txShiftActive_q && bitTick) begin
            txShift_q <= {1'b1, txShift_q[9:1]};
            txCount_q <= txCount_q - 4'h1;
        end
    end

    // Serial output idles high.
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            txLine <= 1'b1;
        end else begin
            txLine <= txShiftActive_q ? txShift_q[0] : 1'b1;
        end
    end

    // ==========================================================
    // APB read data
    logic [7:0] statusByte;
    assign statusByte = {2'b00, txBufValid_q, txShiftActive_q, 1'b0,
                         parity_q, framing_q, overrun_q}; // [RULE_18]

    // Read mux; unmapped and trigger addresses return zero.
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            prdata <= 32'h0000_0000;
            pslverr <= 1'b0;
        end else if (psel && !penable) begin
            pslverr <= 1'b0;
            case (paddr)
                uart_status_pkg::BAUD_DIVISOR_ADDR: prdata <= {24'h0, baudDivisor_q};
                uart_status_pkg::LINE_STATUS_ADDR: prdata <= {24'h0, statusByte};
                uart_status_pkg::ERROR_CLEAR_TRIGGER_ADDR: prdata <= 32'h0000_0000; // [RULE_11]
                uart_status_pkg::CHANNEL_CONTROL_ADDR: prdata <= {24'h0, channelControl_q};
                uart_status_pkg::FRAME_FORMAT_ADDR: prdata <= {24'h0, frameFormat_q};
                uart_status_pkg::RX_BUFFER_ADDR: prdata <= {24'h0, rxBuffer_q};
                default: begin
                    prdata <= 32'h0000_0000;
                    pslverr <= !(paddr == uart_status_pkg::TX_BUFFER_ADDR);
                end
            endcase
        end else begin
            pslverr <= 1'b0; // The error response stands for the access cycle only.
        end
    end
endmodule : uart_baud_status_errors

// File: core/uart_status_pkg.sv
// Purpose: Constants shared by the serial channel baud, status and error-clear logic.
// Assumes: One clock; registers are reached over APB with 32-bit data.
// Notes: Printed offsets are not all multiples of four, so they are word indices.
// How it works
// RULE_01 - Eight-bit divisor counter, values 0x02..0xFF valid
// RULE_02 - Bit rate is half the counter output
// RULE_03 - Software changes divisor only while stopped
// RULE_04 - Overrun flag bit 0 on unread buffer
// RULE_05 - Overrun drops new byte, keeps old one
// RULE_06 - Framing flag bit 1 on missing stop
// RULE_07 - Only the first stop bit is checked
// RULE_08 - Parity flag bit 2 on parity mismatch
// RULE_09 - Clearing operation or receive permit clears errors
// RULE_10 - Writing one to trigger bit clears flag
// RULE_11 - Trigger register always reads zero
// RULE_12 - Flag clears on next clock after write
// RULE_13 - Buffer-valid flag bit 5 set/cleared by transfers
// RULE_14 - Shift-active flag bit 4 set/cleared by shifting
// RULE_15 - Software checks buffer-valid before next write
// RULE_16 - Buffer-empty interrupt mode skips that check
// RULE_17 - Wait shift-idle before clearing transmit permit
// RULE_18 - Unused status bits read zero, all read-only
// RULE_19 - Zero-parity mode performs no parity check
// RULE_20 - Clearing operation resets status and receive buffer
// RULE_21 - Counter pulses exactly every divisor cycles
package uart_status_pkg;
    // Register word indices and the byte addresses derived from them.
    localparam logic [7:0] BAUD_DIVISOR_IDX = 8'h04;
    localparam logic [7:0] LINE_STATUS_IDX = 8'h05;
    localparam logic [7:0] ERROR_CLEAR_TRIGGER_IDX = 8'h06;
    localparam logic [7:0] CHANNEL_CONTROL_IDX = 8'h08;
    localparam logic [7:0] FRAME_FORMAT_IDX = 8'h09;
    localparam logic [7:0] TX_BUFFER_IDX = 8'h0A;
    localparam logic [7:0] RX_BUFFER_IDX = 8'h0B;
    localparam logic [11:0] BAUD_DIVISOR_ADDR = {2'h0, BAUD_DIVISOR_IDX, 2'h0};
    localparam logic [11:0] LINE_STATUS_ADDR = {2'h0, LINE_STATUS_IDX, 2'h0};
    localparam logic [11:0] ERROR_CLEAR_TRIGGER_ADDR = {2'h0, ERROR_CLEAR_TRIGGER_IDX, 2'h0};
    localparam logic [11:0] CHANNEL_CONTROL_ADDR = {2'h0, CHANNEL_CONTROL_IDX, 2'h0};
    localparam logic [11:0] FRAME_FORMAT_ADDR = {2'h0, FRAME_FORMAT_IDX, 2'h0};
    localparam logic [11:0] TX_BUFFER_ADDR = {2'h0, TX_BUFFER_IDX, 2'h0};
    localparam logic [11:0] RX_BUFFER_ADDR = {2'h0, RX_BUFFER_IDX, 2'h0};
    // Divisor reset value and minimum valid divisor.
    localparam logic [7:0] BAUD_DIVISOR_RESET = 8'hFF;
    localparam logic [7:0] BAUD_DIVISOR_MIN = 8'h02;
    // Status field positions.
    localparam int OVERRUN_BIT = 0;
    localparam int FRAMING_BIT = 1;
    localparam int PARITY_BIT = 2;
    localparam int TX_SHIFT_BIT = 4;
    localparam int TX_BUFFER_BIT = 5;
    // Channel control field positions.
    localparam int RX_PERMIT_BIT = 5;
    localparam int TX_PERMIT_BIT = 6;
    localparam int OPERATE_BIT = 7;
    // Frame format field positions.
    localparam int PARITY_LSB = 5;
    // Parity modes.
    typedef enum logic [1:0] {
        PARITY_NONE,
        PARITY_ZERO,
        PARITY_ODD,
        PARITY_EVEN
    } parity_mode_t;
    // Frame bit counts: start, eight data, optional parity, one stop.
    localparam logic [3:0] DATA_BITS = 4'h8;
endpackage : uart_status_pkg

// File: core/baud_divider.sv
// Purpose: Eight-bit divisor counter and bit clock halving stage.
// Assumes: Divisor is stable while the channel runs.
// Notes: Pulse outputs last one clock cycle.
`timescale 1ns/1ps
module baud_divider (
    // Clock and reset.
    input wire logic ref_clk,
    input wire logic reset_n,
    // Control.
    input wire logic run,
    input wire logic [7:0] divisor,
    // Rate outputs.
    output logic counterPulse,
    output logic bitTick
);
    logic [7:0] count_q;
    logic half_q;

    // Counts from one to the divisor, then pulses and restarts.
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            count_q <= 8'h01;
            counterPulse <= 1'b0;
        end else if (!run) begin
            count_q <= 8'h01;
            counterPulse <= 1'b0;
        end else if (count_q >= divisor) begin // [RULE_01] [RULE_21]
            count_q <= 8'h01;
            counterPulse <= 1'b1;
        end else begin
            count_q <= count_q + 8'h01;
            counterPulse <= 1'b0;
        end
    end

    // Toggles on each counter pulse; a bit tick every second pulse halves the rate.
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            half_q <= 1'b0;
            bitTick <= 1'b0;
        end else if (!run) begin
            half_q <= 1'b0;
            bitTick <= 1'b0;
        end else begin
            bitTick <= counterPulse && half_q; // [RULE_02]
            if (counterPulse) begin
                half_q <= ~half_q;
            end
        end
    end
endmodule : baud_divider

// File: tb/uart_baud_status_errors_properties.sv
// Purpose: Port-level checks for the baud, status and error-clear register slave.
// Assumes: One clock domain; APB answers in the first access cycle.
// Notes: Serial bit widths are judged from the low runs seen on txLine.
`timescale 1ns/1ps
module uart_status_properties (
    // Clock and reset.
    input wire logic ref_clk,
    input wire logic reset_n,
    // APB slave.
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    // Serial line.
    input wire logic rxLine,
    input wire logic txLine
);
    // ==========
    // Helper state
    logic [7:0] divQ;
    logic [15:0] lowRunQ;
    logic rdAny;
    logic mapped;
    // A completed read, and whether its word index is one the block decodes.
    assign rdAny = pready && !pwrite;
    assign mapped = paddr[11:6] == 6'h00 && paddr[1:0] == 2'h0 &&
        paddr[5:2] inside {4'h4, 4'h5, 4'h6, 4'h8, 4'h9, 4'hA, 4'hB};
    // Shadow of the divisor, updated when a write to it completes.
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            divQ <= uart_status_pkg::BAUD_DIVISOR_RESET;
        end else if (pready && pwrite && paddr == uart_status_pkg::BAUD_DIVISOR_ADDR) begin
            divQ <= pwdata[7:0];
        end
    end
    // Counts the cycles that txLine has been low.
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            lowRunQ <= 16'h0000;
        end else begin
            lowRunQ <= txLine ? 16'h0000 : lowRunQ + 16'h0001;
        end
    end
    // ==========
    // Assertions
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!reset_n);
    a_ready_after_setup: assert property (psel && !penable |=> pready)
        else $error("pready missing after setup");
    a_ready_in_access: assert property (pready |-> psel && penable && $past(psel) && !$past(penable))
        else $error("pready outside first access cycle");
    a_ready_one_cycle: assert property (pready |=> !pready)
        else $error("pready longer than one cycle");
    a_trigger_reads_zero: assert property (
        rdAny && paddr == uart_status_pkg::ERROR_CLEAR_TRIGGER_ADDR |-> prdata == 32'h00000000)
        else $error("trigger register read not zero");
    a_status_unused_zero: assert property (
        rdAny && paddr == uart_status_pkg::LINE_STATUS_ADDR |-> prdata[7:6] == 2'h0 && !prdata[3])
        else $error("unused status bits not zero");
    a_upper_bytes_zero: assert property (rdAny |-> prdata[31:8] == 24'h000000)
        else $error("upper read bytes not zero");
    a_slverr_decode: assert property (pready |-> pslverr == !mapped)
        else $error("pslverr does not follow address decode");
    a_slverr_with_ready: assert property (pslverr |-> pready)
        else $error("pslverr outside access cycle");
    a_bit_width: assert property (
        $rose(txLine) |-> lowRunQ % {divQ, 1'b0} == 16'h0000)
        else $error("serial bit width not twice the divisor");
    // Main scenarios.
    c_parity_flag: cover property (rdAny && paddr == uart_status_pkg::LINE_STATUS_ADDR && prdata[2]);
    c_slverr: cover property (pready && pslverr);
    c_tx_bit: cover property ($rose(txLine));
endmodule : uart_status_properties

bind uart_baud_status_errors uart_status_properties u_props (
    .ref_clk(ref_clk), .reset_n(reset_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .rxLine(rxLine), .txLine(txLine)
);

// File: tb/serial_peer.sv
// Purpose: Remote serial device that sends frames and captures transmitted bytes.
// Assumes: Line idles high; one bit lasts bitCycles clock cycles.
// Notes: Frames are timed on ref_clk, so bit edges never drift.
`timescale 1ns/1ps
module serial_peer (
    // Clock.
    input wire logic ref_clk,
    // Serial lines seen from the remote side.
    input wire logic txLine,
    output logic rxLine
);
    int bitCycles = 8;
    logic [7:0] gotBytes[$];
    logic [7:0] shiftQ;
    initial rxLine = 1'b1;
    // Sends start, eight data bits LSB first, optional parity and one stop bit.
    task automatic send_frame(input logic [7:0] data, input logic withPar, input logic par,
        input logic stopBit);
        logic [10:0] bits;
        int n;
        bits = {stopBit, par, data, 1'b0};
        n = withPar ? 11 : 10;
        if (!withPar) begin
            bits[9] = stopBit;
        end
        for (int i = 0; i < n; i++) begin
            @(posedge ref_clk);
            rxLine <= bits[i];
            repeat (bitCycles - 1) @(posedge ref_clk);
        end
        if (!stopBit) begin
            @(posedge ref_clk);
            rxLine <= 1'b1;
        end
    endtask : send_frame
    // Samples each transmitted bit in its middle and queues the byte.
    initial begin
        forever begin
            @(negedge txLine);
            repeat (bitCycles / 2) @(posedge ref_clk);
            for (int i = 0; i < 8; i++) begin
                repeat (bitCycles) @(posedge ref_clk);
                shiftQ[i] = txLine;
            end
            repeat (bitCycles) @(posedge ref_clk);
            wait (txLine === 1'b1);
            gotBytes.push_back(shiftQ);
        end
    end
endmodule : serial_peer

// File: tb/uart_baud_status_errors_bench.sv
// Purpose: Self-checking bench for the baud, status and error-clear slave.
// Assumes: Divisor 4, so one serial bit lasts 8 clock cycles.
// Notes: Every scenario is its own task and judges its own results.
`timescale 1ns/1ps
module uart_baud_status_errors_bench;
    // ==========
    // Signals and instances
    localparam logic [11:0] DIV_A = uart_status_pkg::BAUD_DIVISOR_ADDR;
    localparam logic [11:0] STAT_A = uart_status_pkg::LINE_STATUS_ADDR;
    localparam logic [11:0] TRIG_A = uart_status_pkg::ERROR_CLEAR_TRIGGER_ADDR;
    localparam logic [11:0] CTRL_A = uart_status_pkg::CHANNEL_CONTROL_ADDR;
    localparam logic [11:0] FMT_A = uart_status_pkg::FRAME_FORMAT_ADDR;
    localparam logic [11:0] TX_A = uart_status_pkg::TX_BUFFER_ADDR;
    localparam logic [11:0] RX_A = uart_status_pkg::RX_BUFFER_ADDR;
    logic ref_clk = 1'b0;
    logic reset_n = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h00000000;
    logic [31:0] prdata, rdQ;
    logic pready, pslverr, errQ, rxLine, txLine;
    int err_total = 0;
    int comparisons = 0;
    uart_baud_status_errors u_dut (.ref_clk(ref_clk), .reset_n(reset_n), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .rxLine(rxLine), .txLine(txLine));
    serial_peer u_peer (.ref_clk(ref_clk), .txLine(txLine), .rxLine(rxLine));
    // Free-running 50 MHz clock.
    always #10 ref_clk = ~ref_clk;
    // ==========
    // Shared tasks
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            err_total++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask : check
    // One APB transfer; read data and error response are taken at the ready edge.
    task automatic apb(input logic wr, input logic [11:0] addr, input logic [7:0] data);
        int n;
        n = 0;
        @(posedge ref_clk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= addr;
        pwdata <= {24'h000000, data};
        @(posedge ref_clk);
        penable <= 1'b1;
        do begin
            @(posedge ref_clk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        rdQ = prdata;
        errQ = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (n >= 50) begin
            check("pready wait", 32'h0, 32'h1);
        end
    endtask : apb
    task automatic rd(input logic [11:0] addr, input logic [31:0] exp, input string what);
        apb(1'b0, addr, 8'h00);
        check(what, rdQ, exp);
    endtask : rd
    // Receives one frame and lets the receiver finish.
    task automatic rx(input logic [7:0] d, input logic wp, input logic p, input logic stp);
        u_peer.send_frame(d, wp, p, stp);
        repeat (20) @(posedge ref_clk);
    endtask : rx
    // Polls line_status until the masked bits equal want.
    task automatic poll(input logic [7:0] mask, input logic [7:0] want);
        int n;
        n = 0;
        do begin
            apb(1'b0, STAT_A, 8'h00);
            n++;
        end while ((rdQ[7:0] & mask) !== want && n < 300);
        check("status poll", {24'h0, rdQ[7:0] & mask}, {24'h0, want});
    endtask : poll
    // ==========
    // Scenarios
    task automatic t_reset;
        rd(DIV_A, 32'h000000FF, "divisor reset");
        rd(STAT_A, 32'h0, "status reset");
        rd(TRIG_A, 32'h0, "trigger read");
        apb(1'b0, 12'h3FC, 8'h00);
        check("unmapped slverr", {31'h0, errQ}, 32'h1);
        apb(1'b1, STAT_A, 8'hFF);
        rd(STAT_A, 32'h0, "status read-only");
        apb(1'b1, DIV_A, 8'h04);
        rd(DIV_A, 32'h00000004, "divisor write");
        apb(1'b1, FMT_A, 8'h60);
        apb(1'b1, CTRL_A, 8'hE0);
    endtask : t_reset
    task automatic t_errors;
        rx(8'hA5, 1'b1, 1'b0, 1'b1);
        rd(RX_A, 32'h000000A5, "rx byte");
        rx(8'h3C, 1'b1, 1'b1, 1'b1);
        apb(1'b0, RX_A, 8'h00);
        rd(STAT_A, 32'h00000004, "parity flag");
        apb(1'b1, TRIG_A, 8'h03);
        rd(STAT_A, 32'h00000004, "zero trigger keeps");
        apb(1'b1, TRIG_A, 8'h04);
        rd(STAT_A, 32'h0, "parity clear");
        rx(8'h81, 1'b1, 1'b0, 1'b0);
        apb(1'b0, RX_A, 8'h00);
        rd(STAT_A, 32'h00000002, "framing flag");
        apb(1'b1, TRIG_A, 8'h02);
        u_peer.send_frame(8'h11, 1'b1, 1'b0, 1'b1);
        rx(8'h22, 1'b1, 1'b0, 1'b1);
        rd(STAT_A, 32'h00000001, "overrun flag");
        rd(RX_A, 32'h00000011, "overrun keeps byte");
        apb(1'b1, CTRL_A, 8'h80);
        rd(STAT_A, 32'h0, "rx permit clears");
    endtask : t_errors
    // Every parity mode with 8'h07; zero mode gets parity 1 and must not flag it.
    task automatic t_modes;
        for (int m = 0; m < 4; m++) begin
            apb(1'b1, CTRL_A, 8'h80);
            apb(1'b1, FMT_A, 8'(m << 5));
            apb(1'b1, CTRL_A, 8'hE0);
            rx(8'h07, m != 0, m == 1 || m == 3, 1'b1);
            rd(STAT_A, 32'h0, "mode status");
            rd(RX_A, 32'h00000007, "mode byte");
        end
    endtask : t_modes
    task automatic t_transmit;
        apb(1'b1, TX_A, 8'h5A);
        apb(1'b0, STAT_A, 8'h00);
        check("tx busy", {31'h0, rdQ[5] | rdQ[4]}, 32'h1);
        poll(8'h20, 8'h00);
        check("shift active", {31'h0, rdQ[4]}, 32'h1);
        apb(1'b1, TX_A, 8'hC3);
        poll(8'h30, 8'h00);
        check("tx count", u_peer.gotBytes.size(), 32'h2);
        check("tx first", {24'h0, u_peer.gotBytes[0]}, 32'h0000005A);
        check("tx second", {24'h0, u_peer.gotBytes[1]}, 32'h000000C3);
    endtask : t_transmit
    task automatic t_disable;
        rx(8'h66, 1'b1, 1'b0, 1'b0);
        rd(STAT_A, 32'h00000002, "framing again");
        apb(1'b1, CTRL_A, 8'h00);
        rd(STAT_A, 32'h0, "operate off status");
        rd(RX_A, 32'h0, "operate off buffer");
    endtask : t_disable
    // ==========
    // Run control
    task automatic complete_run;
        if (err_total == 0 && comparisons > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : complete_run
    // Main sequence after a two-cycle reset.
    initial begin
        repeat (2) @(posedge ref_clk);
        reset_n <= 1'b1;
        t_reset();
        t_errors();
        t_modes();
        t_transmit();
        t_disable();
        complete_run();
    end
    // Watchdog at 20000 cycles, well beyond the expected run of under two thousand cycles.
    initial begin
        #400000;
        err_total++;
        complete_run();
    end
endmodule : uart_baud_status_errors_bench
